// [verilog/agc_pkg.sv]
// constants and types shared by the automatic gain controller
package agc_pkg;

    // ------------------------------------
    // register port geometry and offsets
    // ------------------------------------
    localparam int         ADDR_W      = 4;
    localparam int         DATA_W      = 8;
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_FIXED   = 4'h1;
    localparam logic [3:0] OFS_MAXG    = 4'h2;
    localparam logic [3:0] OFS_LIMIT   = 4'h3;
    localparam logic [3:0] OFS_NGATE   = 4'h4;
    localparam logic [3:0] OFS_ATTACK  = 4'h5;
    localparam logic [3:0] OFS_RELEASE = 4'h6;
    localparam logic [3:0] OFS_HOLD    = 4'h7;
    localparam logic [3:0] OFS_GAIN    = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'h9;

    // ------------------------------------
    // control and status field positions
    // ------------------------------------
    localparam int CTRL_AGC_EN   = 0;
    localparam int CTRL_COMP_EN  = 1;
    localparam int CTRL_LIM_EN   = 2;
    localparam int CTRL_HOLD_EN  = 3;
    localparam int CTRL_SHDN     = 4;
    localparam int CTRL_RATIO_LO = 5;
    localparam int CTRL_RATIO_HI = 6;
    localparam int STAT_ACTIVE   = 0;
    localparam int STAT_FROZEN   = 1;
    localparam int STAT_LIMITING = 2;
    localparam int STAT_LAST_DN  = 3;
    localparam int STAT_AT_MAX   = 4;
    localparam int STAT_AT_MIN   = 5;

    // ------------------------------------
    // reset values
    // ------------------------------------
    localparam logic [7:0] CTRL_RST    = 8'h2F;  // on, 2:1, hold on
    localparam logic [7:0] FIXED_RST   = 8'h06;  // 6 dB
    localparam logic [7:0] MAXG_RST    = 8'h1E;  // 30 dB
    localparam logic [7:0] LIMIT_RST   = 8'h0C;  // 6 dBV
    localparam logic [7:0] NGATE_RST   = 8'hA0;  // -48 dBV
    localparam logic [7:0] ATTACK_RST  = 8'h05;
    localparam logic [7:0] RELEASE_RST = 8'h0A;
    localparam logic [7:0] HOLD_RST    = 8'h14;

    // ------------------------------------
    // timing: fine tick paces attack, coarse tick release and hold
    // ------------------------------------
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         FINE_TICK_NS   = 100000;
    localparam int         FINE_TICK_CYC  = FINE_TICK_NS / CLK_PERIOD_NS;
    localparam int         COARSE_TICK_NS = 10000000;
    localparam int         COARSE_PER_FINE = COARSE_TICK_NS / FINE_TICK_NS;
    localparam int         PRE_W          = 10;
    localparam int         CRS_W          = 7;
    localparam logic [9:0] FINE_LAST      = 10'(FINE_TICK_CYC - 1);
    localparam logic [6:0] COARSE_LAST    = 7'(COARSE_PER_FINE - 1);

    // ------------------------------------
    // gain arithmetic, levels in half-decibel units except the FIX_* and MAXG_TOP limits in whole dB
    // ------------------------------------
    localparam int                GAIN_W       = 10;
    localparam int                GOUT_W       = 7;
    localparam logic signed [9:0] GAIN_STEP    = 10'sd1;   // 0.5 dB
    localparam logic signed [9:0] GAIN_MIN     = -10'sd56; // -28 dB
    localparam logic signed [9:0] GAIN_MAX     = 10'sd60;  // 30 dB
    localparam logic signed [9:0] FIX_MIN_COMP = -10'sd28; // whole dB
    localparam logic signed [9:0] FIX_MIN_NOCP = 10'sd0;
    localparam logic signed [9:0] FIX_MAX      = 10'sd30;
    localparam logic        [4:0] MAXG_TOP     = 5'd30;
    localparam logic signed [9:0] PIVOT_LVL    = 10'sd20;  // 10 dBV
    localparam logic signed [9:0] DEADBAND     = 10'sd1;

    // ------------------------------------
    // controller states
    // ------------------------------------
    typedef enum logic [2:0] {
        ST_FIXED  = 3'b001,
        ST_RUN    = 3'b010,
        ST_FROZEN = 3'b100
    } agc_state_t;

endpackage

// [verilog/agc_timer.sv]
// interval counter that gates attack, release and hold steps
`timescale 1ns/1ps
module agc_timer
    import agc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // control
    input  wire logic       restart,
    input  wire logic       tick,
    input  wire logic [7:0] load_val,
    // status
    output logic            done
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;

    // ------------------------------------
    // count down on ticks, reload on every gain step
    // ------------------------------------
    always_comb begin
        next_cnt = cnt;
        if (restart) begin
            next_cnt = load_val;
        end else if (tick && cnt != 8'h00) begin
            next_cnt = cnt - 8'h01;
        end
    end

    // count register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

    // interval over once the count reaches zero
    assign done = (cnt == 8'h00);

endmodule

// [verilog/agc_gain_ctrl.sv]
// automatic gain controller: envelope in, gain step decisions out
//
// Functional notes
// [R1] each automatic gain change moves exactly one half-decibel step
// [R2] successive decreases are spaced by at least the attack interval
// [R3] successive increases are spaced by at least the release interval
// [R4] first increase after a decrease waits for the hold interval
// [R5] envelope below noise gate freezes gain, no steps taken
// [R6] gain loads the fixed setting on leaving shutdown or when disabled
// [R7] with automatic control inactive the gain equals the fixed setting
// [R8] maximum gain bounds the target; gain never raised above it (code still loads a fixed setting above it when inactive or enabling)
// [R9] gain reduced while output stays above the limiter level
// [R10] nearly constant envelope leaves gain unchanged
// [R11] above limiter with no attack pending, decrease now, restart timers
// [R12] still above limiter when attack ends: one step down, timers restart
// [R13] release over and output below target: one step up, timers restart
// [R14] fixed gain -28..30 dB with compression, 0..30 dB without
// [R15] ratio N:1 gives one dB output change per N dB input change
// [R16] gain change equals input change times one minus one over ratio
// [R17] compression curve pivots at 10 dBV input, fixed gain shifts output
// [R18] all three timers restart after every gain step
// [R19] hold replaces release only for first increase, release when off
// [R20] intervals are clock-driven counters reloaded and compared to zero
// [R21] gain code saturates at its lowest and highest step values
`timescale 1ns/1ps
module agc_gain_ctrl
    import agc_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // envelope detector, level in half-dBV
    input  wire logic signed [7:0] env_level,
    // programmable gain amplifier
    output logic signed [GOUT_W-1:0] gain_code,
    output logic                   step_up,
    output logic                   step_down,
    output logic                   agc_active
);

    // ------------------------------------
    // software settings
    // ------------------------------------
    logic [7:0] ctrl, fixed, maxg, limit, ngate, t_att, t_rel, t_hold;
    logic [7:0] next_ctrl, next_fixed, next_maxg, next_limit;
    logic [7:0] next_ngate, next_t_att, next_t_rel, next_t_hold;
    logic [7:0] next_rdata, status;
    logic signed [GAIN_W-1:0] gain;

    // register writes steer the settings
    always_comb begin
        next_ctrl   = ctrl;
        next_fixed  = fixed;
        next_maxg   = maxg;
        next_limit  = limit;
        next_ngate  = ngate;
        next_t_att  = t_att;
        next_t_rel  = t_rel;
        next_t_hold = t_hold;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_CTRL:    next_ctrl   = reg_wdata;
                OFS_FIXED:   next_fixed  = reg_wdata;
                OFS_MAXG:    next_maxg   = reg_wdata;
                OFS_LIMIT:   next_limit  = reg_wdata;
                OFS_NGATE:   next_ngate  = reg_wdata;
                OFS_ATTACK:  next_t_att  = reg_wdata;
                OFS_RELEASE: next_t_rel  = reg_wdata;
                OFS_HOLD:    next_t_hold = reg_wdata;
                default:     next_ctrl   = ctrl;  // read-only or unmapped
            endcase
        end
    end

    // read data valid only in the cycle after the read strobe
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL:    next_rdata = ctrl;
                OFS_FIXED:   next_rdata = fixed;
                OFS_MAXG:    next_rdata = maxg;
                OFS_LIMIT:   next_rdata = limit;
                OFS_NGATE:   next_rdata = ngate;
                OFS_ATTACK:  next_rdata = t_att;
                OFS_RELEASE: next_rdata = t_rel;
                OFS_HOLD:    next_rdata = t_hold;
                OFS_GAIN:    next_rdata = gain[7:0];
                OFS_STATUS:  next_rdata = status;
                default:     next_rdata = 8'h00;
            endcase
        end
    end

    // settings and read data registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl      <= CTRL_RST;
            fixed     <= FIXED_RST;
            maxg      <= MAXG_RST;
            limit     <= LIMIT_RST;
            ngate     <= NGATE_RST;
            t_att     <= ATTACK_RST;
            t_rel     <= RELEASE_RST;
            t_hold    <= HOLD_RST;
            reg_rdata <= 8'h00;
        end else begin
            ctrl      <= next_ctrl;
            fixed     <= next_fixed;
            maxg      <= next_maxg;
            limit     <= next_limit;
            ngate     <= next_ngate;
            t_att     <= next_t_att;
            t_rel     <= next_t_rel;
            t_hold    <= next_t_hold;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------
    // timebase: fine tick every 0.1 ms, coarse tick every 10 ms
    // ------------------------------------
    logic [PRE_W-1:0] pre_cnt, next_pre_cnt;
    logic [CRS_W-1:0] crs_cnt, next_crs_cnt;
    logic             fine_tick, coarse_tick;

    always_comb begin
        fine_tick    = (pre_cnt == FINE_LAST);
        coarse_tick  = fine_tick && (crs_cnt == COARSE_LAST);
        next_pre_cnt = fine_tick ? '0 : pre_cnt + 10'd1;
        next_crs_cnt = crs_cnt;
        if (coarse_tick) begin
            next_crs_cnt = '0;
        end else if (fine_tick) begin
            next_crs_cnt = crs_cnt + 7'd1;
        end
    end

    // prescaler registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pre_cnt <= '0;
            crs_cnt <= '0;
        end else begin
            pre_cnt <= next_pre_cnt;
            crs_cnt <= next_crs_cnt;
        end
    end

    // ------------------------------------
    // interval timers
    // ------------------------------------
    logic restart_all, att_done, rel_done, hold_done;

    // [R20] counted intervals
    agc_timer u_attack (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .restart  (restart_all),
        .tick     (fine_tick),
        .load_val (t_att),
        .done     (att_done)
    );
    agc_timer u_release (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .restart  (restart_all),
        .tick     (coarse_tick),
        .load_val (t_rel),
        .done     (rel_done)
    );
    agc_timer u_hold (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .restart  (restart_all),
        .tick     (coarse_tick),
        .load_val (t_hold),
        .done     (hold_done)
    );

    // ------------------------------------
    // target gain from the compression curve
    // ------------------------------------
    logic signed [GAIN_W-1:0] fix_db, fix_code, max_code, env_x;
    logic signed [GAIN_W-1:0] lim_x, gate_x, delta, comp, desired, out_lvl;
    logic        [4:0]        maxg_c;
    logic        [1:0]        ratio;
    logic                     en_agc, en_comp, en_lim, en_hold, shdn;
    logic                     gated, over_lim, up_room;

    always_comb begin
        en_agc  = ctrl[CTRL_AGC_EN];
        en_comp = ctrl[CTRL_COMP_EN];
        en_lim  = ctrl[CTRL_LIM_EN];
        en_hold = ctrl[CTRL_HOLD_EN];
        shdn    = ctrl[CTRL_SHDN];
        ratio   = ctrl[CTRL_RATIO_HI:CTRL_RATIO_LO];
        env_x   = GAIN_W'(env_level);
        lim_x   = GAIN_W'($signed(limit));
        gate_x  = GAIN_W'($signed(ngate));
        // [R14] fixed gain range depends on compression
        fix_db  = GAIN_W'($signed(fixed[5:0]));
        if (fix_db > FIX_MAX) begin
            fix_db = FIX_MAX;
        end else if (en_comp && fix_db < FIX_MIN_COMP) begin
            fix_db = FIX_MIN_COMP;
        end else if (!en_comp && fix_db < FIX_MIN_NOCP) begin
            fix_db = FIX_MIN_NOCP;
        end
        fix_code = fix_db <<< 1;
        maxg_c   = (maxg[4:0] > MAXG_TOP) ? MAXG_TOP : maxg[4:0];
        max_code = $signed({4'h0, maxg_c, 1'b0});
        // [R17] input offset measured from the pivot
        delta    = PIVOT_LVL - env_x;
        // [R16] gain change is delta times (1 - 1/ratio)
        comp     = delta - (delta >>> ratio);
        // [R15] ratio field selects 1:1, 2:1, 4:1 or 8:1
        desired  = en_comp ? fix_code + comp : fix_code;
        // [R8] maximum gain caps the target
        if (desired > max_code) begin
            desired = max_code;
        end
        if (desired < GAIN_MIN) begin
            desired = GAIN_MIN;
        end
        out_lvl  = env_x + gain;
        // [R9] output above limiter calls for a decrease
        over_lim = en_lim && (out_lvl > lim_x);
        up_room  = !en_lim || (out_lvl + GAIN_STEP <= lim_x);
        // [R5] noise gate
        gated    = (env_x < gate_x);
    end

    // ------------------------------------
    // step decision and state machine
    // ------------------------------------
    agc_state_t               state, next_state;
    logic signed [GAIN_W-1:0] next_gain;
    logic                     last_dn, next_last_dn;
    logic                     want_dn, want_up, up_ready, do_dn, do_up;
    logic                     next_step_up, next_step_down, next_agc_active;

    always_comb begin
        // [R10] dead band keeps gain still on a steady envelope
        want_dn  = over_lim || (gain > desired + DEADBAND);
        want_up  = (gain < desired - DEADBAND) && up_room;
        // [R4] [R19] hold after a decrease, release otherwise
        up_ready = (last_dn && en_hold) ? hold_done : rel_done;
        // [R2] [R11] [R12] decrease only once attack is over
        do_dn    = (state == ST_RUN) && !gated && want_dn && att_done
                   && (gain > GAIN_MIN);
        // [R3] [R13] increase only once release or hold is over
        do_up    = (state == ST_RUN) && !want_dn && want_up && up_ready
                   && !gated && (gain < GAIN_MAX) && (gain < max_code);
        // [R18] every step restarts all timers
        restart_all    = do_dn || do_up;
        next_state     = state;
        next_gain      = gain;
        next_last_dn   = last_dn;
        next_step_up   = do_up;
        next_step_down = do_dn;
        unique case (state)
            ST_FIXED: begin
                // [R6] [R7] inactive control tracks the fixed gain
                next_gain    = fix_code;
                next_last_dn = 1'b0;
                if (en_agc && !shdn) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // [R1] [R21] one half-dB step, guarded at both ends
                if (do_dn) begin
                    next_gain    = gain - GAIN_STEP;
                    next_last_dn = 1'b1;
                end else if (do_up) begin
                    next_gain    = gain + GAIN_STEP;
                    next_last_dn = 1'b0;
                end
                if (!en_agc || shdn) begin
                    next_state = ST_FIXED;
                end else if (gated) begin
                    next_state = ST_FROZEN;
                end
            end
            ST_FROZEN: begin
                // [R5] gain held while below the noise gate
                if (!en_agc || shdn) begin
                    next_state = ST_FIXED;
                end else if (!gated) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_FIXED;
        endcase
        next_agc_active = (next_state != ST_FIXED);
    end

    // controller registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state     <= ST_FIXED;
            gain      <= '0;
            last_dn   <= 1'b0;
            step_up   <= 1'b0;
            step_down <= 1'b0;
            agc_active <= 1'b0;
        end else begin
            state     <= next_state;
            gain      <= next_gain;
            last_dn   <= next_last_dn;
            step_up   <= next_step_up;
            step_down <= next_step_down;
            agc_active <= next_agc_active;
        end
    end

    // ------------------------------------
    // outputs and status
    // ------------------------------------
    always_comb begin
        status                = 8'h00;
        status[STAT_ACTIVE]   = (state != ST_FIXED);
        status[STAT_FROZEN]   = (state == ST_FROZEN);
        status[STAT_LIMITING] = over_lim;
        status[STAT_LAST_DN]  = last_dn;
        status[STAT_AT_MAX]   = (gain >= max_code);
        status[STAT_AT_MIN]   = (gain <= GAIN_MIN);
    end

    assign gain_code = gain[GOUT_W-1:0];

endmodule

// [sim/agc_gain_ctrl_asserts.sv]
// port checker for the automatic gain controller
`timescale 1ns/1ps
module agc_gain_ctrl_chk
    import agc_pkg::*;
(
    // clock and reset
    input wire logic                     clk_sys,
    input wire logic                     sys_rst,
    // register port
    input wire logic [ADDR_W-1:0]        reg_addr,
    input wire logic [DATA_W-1:0]        reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [DATA_W-1:0]        reg_rdata,
    // envelope and amplifier
    input wire logic signed [7:0]        env_level,
    input wire logic signed [GOUT_W-1:0] gain_code,
    input wire logic                     step_up,
    input wire logic                     step_down,
    input wire logic                     agc_active
);
    // ------------------------------------------------------------
    // shadow state
    // ------------------------------------------------------------
    logic [31:0] since, next_since;
    logic [7:0]  att, next_att, rel, next_rel;
    logic        up_last, next_up_last;

    // saturating age of last step, interval shadows
    always_comb begin
        next_since = (step_up || step_down) ? 32'h0
                   : since + {31'h0, ~since[31]};
        next_att = (reg_wr && reg_addr == OFS_ATTACK) ? reg_wdata : att;
        next_rel = (reg_wr && reg_addr == OFS_RELEASE) ? reg_wdata : rel;
        next_up_last = step_up ? 1'h1 : (step_down ? 1'h0 : up_last);
    end

    // shadow registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            since   <= 32'h80000000;
            att     <= ATTACK_RST;
            rel     <= RELEASE_RST;
            up_last <= 1'h0;
        end else begin
            since   <= next_since;
            att     <= next_att;
            rel     <= next_rel;
            up_last <= next_up_last;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_down_one_step: assert property (
        step_down |-> gain_code == $past(gain_code) - 7'sh1)
        else $error("down step is not one unit");
    a_up_one_step: assert property (
        step_up |-> gain_code == $past(gain_code) + 7'sh1)
        else $error("up step is not one unit");
    a_steps_exclusive: assert property (!(step_up && step_down))
        else $error("both step pulses high");
    a_gain_frozen: assert property (
        agc_active && $past(agc_active) && !step_up && !step_down
        |-> $stable(gain_code))
        else $error("gain moved without a step");
    a_gain_bounds: assert property (
        gain_code >= GAIN_MIN && gain_code <= GAIN_MAX)
        else $error("gain outside its range");
    a_idle_no_step: assert property (
        !agc_active && !$past(agc_active) |-> !step_up && !step_down)
        else $error("step while control inactive");
    a_attack_gap: assert property (
        step_down && att != 8'h0 |->
        since + 32'h2 > ({24'h0, att} - 32'h1) * FINE_TICK_CYC)
        else $error("decreases closer than attack interval");
    a_release_gap: assert property (
        step_up && up_last && rel != 8'h0 |-> since + 32'h2 >
        ({24'h0, rel} - 32'h1) * FINE_TICK_CYC * COARSE_PER_FINE)
        else $error("increases closer than release interval");
    a_gain_readback: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_GAIN
        |-> reg_rdata == 8'($past(gain_code)))
        else $error("gain read differs from gain port");
endmodule

bind agc_gain_ctrl agc_gain_ctrl_chk u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .env_level(env_level),
    .gain_code(gain_code), .step_up(step_up), .step_down(step_down),
    .agc_active(agc_active));

// [sim/agc_env_model.sv]
// envelope detector and amplifier level model
`timescale 1ns/1ps
module agc_env_model (
    // clock
    input wire logic               clk_sys,
    // audio side
    input wire logic signed [7:0]  in_level,
    input wire logic signed [6:0]  gain_code,
    // detector and output
    output logic signed [7:0]      env_level,
    output logic signed [8:0]      out_level
);
    // envelope follows the input one clock late
    always @(posedge clk_sys) env_level <= in_level;

    // output level in half-dB units
    assign out_level = 9'(in_level) + 9'(gain_code);
endmodule

// [sim/agc_gain_ctrl_tb.sv]
// self-checking bench for the automatic gain controller
`timescale 1ns/1ps
module agc_gain_ctrl_tb
    import agc_pkg::*;
;
    localparam logic [7:0] RST_V [8] = '{CTRL_RST, FIXED_RST, MAXG_RST,
        LIMIT_RST, NGATE_RST, ATTACK_RST, RELEASE_RST, HOLD_RST};
    // control, fixed setting, expected gain read
    localparam logic [7:0] ROWS [5][3] = '{'{8'h26, 8'hFB, 8'hF6},
        '{8'h26, 8'hE0, 8'hC8}, '{8'h24, 8'hFB, 8'h00},
        '{8'h24, 8'h1E, 8'h3C}, '{8'h37, 8'h0C, 8'h18}};
    logic                     clk_sys;
    logic                     sys_rst;
    logic [ADDR_W-1:0]        reg_addr;
    logic [DATA_W-1:0]        reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [DATA_W-1:0]        reg_rdata;
    logic                     rd_q = 1'h0;
    logic signed [7:0]        in_level;
    logic signed [7:0]        env_level;
    logic signed [8:0]        out_level;
    logic signed [GOUT_W-1:0] gain_code;
    logic                     step_up;
    logic                     step_down;
    logic                     agc_active;
    logic [7:0]               exp_q [$];
    int                       fails = 0;
    int                       total_checks = 0;
    int                       n;

    agc_gain_ctrl DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .env_level(env_level),
        .gain_code(gain_code), .step_up(step_up),
        .step_down(step_down), .agc_active(agc_active));
    agc_env_model u_env (.clk_sys(clk_sys), .in_level(in_level),
        .gain_code(gain_code), .env_level(env_level),
        .out_level(out_level));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] want);
        reg_addr <= a;
        reg_rd <= 1'h1;
        exp_q.push_back(want);
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(posedge clk_sys);
    endtask

    // cycles until the next down pulse, bounded
    task automatic wait_down(output int cyc);
        cyc = 0;
        do begin
            @(negedge clk_sys);
            cyc++;
        end while (step_down !== 1'h1 && cyc < 3000);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, read monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    // oldest queued read expectation against read data
    always @(posedge clk_sys) begin
        if (rd_q === 1'h1) begin
            chk(reg_rdata, exp_q.pop_front());
        end
        rd_q <= reg_rd;
    end

    initial begin
        #4000000;
        fails++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'h1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        in_level = 8'h9C;
        void'($urandom(47160));
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) rd(4'(i), RST_V[i]);
        rd(4'hA, 8'h00);
        wr(OFS_GAIN, 8'h55);
        rd(OFS_GAIN, 8'h0C);
        repeat (300) @(posedge clk_sys);
        rd(OFS_GAIN, 8'h0C);
        chk(8'(agc_active), 8'h01);
        $display("registers and noise gate done");
        wr(OFS_ATTACK, 8'h02);
        wr(OFS_RELEASE, 8'h00);
        wr(OFS_MAXG, 8'h0A);
        wr(OFS_CTRL, 8'h27);
        in_level <= 8'h04;
        wait_down(n);
        chk(8'(n <= 5), 8'h01);
        repeat (3) begin
            wait_down(n);
            chk(8'(n >= 1000 && n <= 2010), 8'h01);
        end
        repeat (2500) @(posedge clk_sys);
        rd(OFS_GAIN, 8'h08);
        chk(8'(out_level <= 9'sh00C), 8'h01);
        $display("limiter done");
        in_level <= 8'hEC;
        n = 0;
        repeat (600) begin
            @(negedge clk_sys);
            n += step_up;
        end
        chk(8'(n), 8'h0B);
        rd(OFS_GAIN, 8'h13);
        $display("release and maximum gain done");
        in_level <= 8'h9C;
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, ROWS[i][0]);
            wr(OFS_FIXED, ROWS[i][1]);
            repeat (3) @(posedge clk_sys);
            rd(OFS_GAIN, ROWS[i][2]);
            chk(8'(agc_active), 8'h00);
        end
        wr(OFS_CTRL, 8'h27);
        rd(OFS_GAIN, 8'h18);
        chk(8'(agc_active), 8'h01);
        $display("fixed gain done");
        repeat (80) begin
            in_level <= 8'(int'($urandom_range(140)) - 100);
            repeat (50) @(posedge clk_sys);
        end
        $display("random envelope done");
        tally_and_finish();
    end
endmodule
